/* File: src/sskx_defs.svh */
// Constants for the shift, subtract and skip execution datapath.
`ifndef SSKX_DEFS_SVH
`define SSKX_DEFS_SVH
`define SSKX_ALL_ONES 8'hFF
`define SSKX_ONE 8'h01
`define SSKX_RST_ACC 8'h00
`define SSKX_SKIP_CYCLES 2
`define SSKX_FLAG_C 0
`define SSKX_FLAG_AC 1
`define SSKX_FLAG_Z 2
`define SSKX_FLAG_OV 3
`endif

/* File: src/sskx_pkg.sv */
// Types for the shift, subtract and skip execution datapath.
package sskx_pkg;
   typedef enum logic [4:0] {
      sskx_op_none = 5'h00,
      sskx_op_rotate_left_thru_carry = 5'h01,
      sskx_op_rotate_left_thru_carry_to_acc = 5'h02,
      sskx_op_rotate_right = 5'h03,
      sskx_op_rotate_right_to_acc = 5'h04,
      sskx_op_rotate_right_thru_carry = 5'h05,
      sskx_op_rotate_right_thru_carry_to_acc = 5'h06,
      sskx_op_subtract_with_borrow_to_acc = 5'h07,
      sskx_op_subtract_with_borrow_to_mem = 5'h08,
      sskx_op_subtract_to_acc = 5'h09,
      sskx_op_subtract_to_mem = 5'h0A,
      sskx_op_subtract_imm = 5'h0B,
      sskx_op_decrement_skip_zero = 5'h0C,
      sskx_op_decrement_skip_zero_to_acc = 5'h0D,
      sskx_op_increment_skip_zero = 5'h0E,
      sskx_op_increment_skip_zero_to_acc = 5'h0F,
      sskx_op_set_byte = 5'h10,
      sskx_op_set_bit = 5'h11,
      sskx_op_bit_set_skip = 5'h12,
      sskx_op_swap_nibbles = 5'h13
   } sskx_op_type;
   typedef enum logic [0:0] {
      sskx_st_run = 1'b0,
      sskx_st_dummy = 1'b1
   } sskx_state_type;
endpackage

/* File: src/sskx_alu_if.sv */
// Interface between the sequencer and the combinational ALU.
`timescale 1ns/100ps
`default_nettype none
interface sskx_alu_if;
   import sskx_pkg::*;
   sskx_op_type op;
   logic [7:0] acc;
   logic [7:0] mem;
   logic [7:0] imm;
   logic [2:0] bit_sel;
   logic carry_in;
   logic [7:0] result;
   logic to_mem;
   logic to_acc;
   logic skip;
   logic [3:0] flag_we;
   logic [3:0] flag_val;
   modport seq (output op, acc, mem, imm, bit_sel, carry_in,
                input result, to_mem, to_acc, skip, flag_we, flag_val);
   modport alu (input op, acc, mem, imm, bit_sel, carry_in,
                output result, to_mem, to_acc, skip, flag_we, flag_val);
endinterface
`default_nettype wire

/* File: src/sskx_alu.sv */
// Combinational result, destination, skip and flag logic.
`timescale 1ns/100ps
`default_nettype none
`include "sskx_defs.svh"
module sskx_alu
   import sskx_pkg::*;
(
   sskx_alu_if.alu a
);
   function automatic logic [9:0] sskx_sub(input logic [7:0] x, input logic [7:0] y,
                                           input logic cin);
      logic [8:0] s;
      logic [4:0] h;
      logic [7:0] ny;
      ny = ~y;
      s = {1'b0, x} + {1'b0, ny} + {8'h00, cin};
      h = {1'b0, x[3:0]} + {1'b0, ny[3:0]} + {4'h0, cin};
      // Bits: result, carry, half carry.
      sskx_sub = {s[7:0], s[8], h[4]};
   endfunction
   logic [9:0] sub_r;
   logic [7:0] sub_b;
   logic sub_cin;
   always_comb begin
      sub_b = a.mem;
      sub_cin = a.carry_in;
      if (a.op == sskx_op_subtract_imm) begin
         sub_b = a.imm;
      end
      if (a.op != sskx_op_subtract_with_borrow_to_acc &&
          a.op != sskx_op_subtract_with_borrow_to_mem) begin
         sub_cin = 1'b1;
      end
      sub_r = sskx_sub(a.acc, sub_b, sub_cin);
   end
   always_comb begin
      a.result = 8'h00;
      a.to_mem = 1'b0;
      a.to_acc = 1'b0;
      a.skip = 1'b0;
      a.flag_we = 4'h0;
      a.flag_val = 4'h0;
      case (a.op)
         sskx_op_rotate_left_thru_carry, sskx_op_rotate_left_thru_carry_to_acc: begin
            a.result = {a.mem[6:0], a.carry_in};
            a.flag_we[`SSKX_FLAG_C] = 1'b1;
            a.flag_val[`SSKX_FLAG_C] = a.mem[7];
            a.to_acc = (a.op == sskx_op_rotate_left_thru_carry_to_acc);
            a.to_mem = !a.to_acc;
         end
         sskx_op_rotate_right, sskx_op_rotate_right_to_acc: begin
            a.result = {a.mem[0], a.mem[7:1]};
            a.to_acc = (a.op == sskx_op_rotate_right_to_acc);
            a.to_mem = !a.to_acc;
         end
         sskx_op_rotate_right_thru_carry, sskx_op_rotate_right_thru_carry_to_acc: begin
            a.result = {a.carry_in, a.mem[7:1]};
            a.flag_we[`SSKX_FLAG_C] = 1'b1;
            a.flag_val[`SSKX_FLAG_C] = a.mem[0];
            a.to_acc = (a.op == sskx_op_rotate_right_thru_carry_to_acc);
            a.to_mem = !a.to_acc;
         end
         sskx_op_subtract_with_borrow_to_acc, sskx_op_subtract_with_borrow_to_mem,
         sskx_op_subtract_to_acc, sskx_op_subtract_to_mem, sskx_op_subtract_imm: begin
            a.result = sub_r[9:2];
            a.to_mem = (a.op == sskx_op_subtract_with_borrow_to_mem) ||
                       (a.op == sskx_op_subtract_to_mem);
            a.to_acc = !a.to_mem;
            a.flag_we = 4'hF;
            a.flag_val[`SSKX_FLAG_C] = sub_r[1];
            a.flag_val[`SSKX_FLAG_AC] = sub_r[0];
            a.flag_val[`SSKX_FLAG_Z] = (sub_r[9:2] == 8'h00);
            a.flag_val[`SSKX_FLAG_OV] = (a.acc[7] != sub_b[7]) && (sub_r[9] != a.acc[7]);
         end
         sskx_op_decrement_skip_zero, sskx_op_decrement_skip_zero_to_acc: begin
            a.result = a.mem - `SSKX_ONE;
            a.skip = (a.result == 8'h00);
            a.to_acc = (a.op == sskx_op_decrement_skip_zero_to_acc);
            a.to_mem = !a.to_acc;
         end
         sskx_op_increment_skip_zero, sskx_op_increment_skip_zero_to_acc: begin
            a.result = a.mem + `SSKX_ONE;
            a.skip = (a.result == 8'h00);
            a.to_acc = (a.op == sskx_op_increment_skip_zero_to_acc);
            a.to_mem = !a.to_acc;
         end
         sskx_op_set_byte: begin
            a.result = `SSKX_ALL_ONES;
            a.to_mem = 1'b1;
         end
         sskx_op_set_bit: begin
            a.result = a.mem | (8'h01 << a.bit_sel);
            a.to_mem = 1'b1;
         end
         sskx_op_bit_set_skip: begin
            a.skip = a.mem[a.bit_sel];
         end
         sskx_op_swap_nibbles: begin
            a.result = {a.mem[3:0], a.mem[7:4]};
            a.to_mem = 1'b1;
         end
         default: begin
            a.result = 8'h00;
         end
      endcase
   end
endmodule
`default_nettype wire

/* File: src/sskx_exec.sv */
// Top of the shift, subtract and skip execution datapath.
//
// The plain strobed issue port is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
`include "sskx_defs.svh"
module sskx_exec
   import sskx_pkg::*;
#(
   parameter int DATA_W = 8
) (
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic issue_i,
   input wire logic [4:0] op_i,
   input wire logic [7:0] mem_i,
   input wire logic [7:0] imm_i,
   input wire logic [2:0] bit_sel_i,
   input wire logic [7:0] flags_i,
   output logic [7:0] acc_o,
   output logic [3:0] flags_o,
   output logic [7:0] mem_wdata_o,
   output logic mem_we_o,
   output logic acc_we_o,
   output logic discard_o,
   output logic busy_o
);
   // Only an 8-bit datapath is served by the logic below.
   if (DATA_W != 8) begin : g_width_check
      $error("sskx_exec supports only an 8-bit datapath.");
   end
   ////////////////////////////////////////////////////////////////////////
   sskx_alu_if alu_bus();
   sskx_alu alu_u (
      .a(alu_bus)
   );
   logic [7:0] acc_r;
   logic [3:0] flags_r;
   sskx_state_type state_r;
   logic go;
   assign go = issue_i && (state_r == sskx_st_run);
   assign alu_bus.op = go ? sskx_op_type'(op_i) : sskx_op_none;
   assign alu_bus.acc = acc_r;
   assign alu_bus.mem = mem_i;
   assign alu_bus.imm = imm_i;
   assign alu_bus.bit_sel = bit_sel_i;
   assign alu_bus.carry_in = flags_r[`SSKX_FLAG_C];
   ////////////////////////////////////////////////////////////////////////
   // Accumulator holds the result of accumulator-destination forms.
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         acc_r <= `SSKX_RST_ACC;
      end else if (alu_bus.to_acc) begin
         acc_r <= alu_bus.result;
      end
   end
   // Only the flags the instruction names are written.
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         flags_r <= 4'h0;
      end else begin
         flags_r <= (flags_r & ~alu_bus.flag_we) | (alu_bus.flag_val & alu_bus.flag_we);
      end
   end
   // Memory write port for memory-destination forms.
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         mem_we_o <= 1'b0;
         mem_wdata_o <= 8'h00;
         acc_we_o <= 1'b0;
      end else begin
         mem_we_o <= alu_bus.to_mem;
         mem_wdata_o <= alu_bus.result;
         acc_we_o <= alu_bus.to_acc;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // Skip inserts dummy cycle.
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         state_r <= sskx_st_run;
         discard_o <= 1'b0;
         busy_o <= 1'b0;
      end else begin
         case (state_r)
            sskx_st_run: begin
               if (alu_bus.skip) begin
                  state_r <= sskx_st_dummy;
                  discard_o <= 1'b1;
                  busy_o <= 1'b1;
               end
            end
            sskx_st_dummy: begin
               state_r <= sskx_st_run;
               discard_o <= 1'b0;
               busy_o <= 1'b0;
            end
            default: begin
               state_r <= sskx_st_run;
            end
         endcase
      end
   end
   assign acc_o = acc_r;
   assign flags_o = flags_r;
   ////////////////////////////////////////////////////////////////////////
   logic unused_flags;
   assign unused_flags = ^flags_i;
   chk_rlc_carry: assert property (@(posedge clock_i) disable iff (rst_i)
      go && op_i == 5'h01 |=> flags_o[0] == $past(mem_i[7]) && mem_we_o &&
      mem_wdata_o == {$past(mem_i[6:0]), $past(flags_o[0])})
      else $error("rotate left through carry wrong");
   chk_rotate_left_thru_carry_to_acc_acc: assert property (@(posedge clock_i) disable iff (rst_i)
      go && op_i == 5'h02 |=> acc_o == {$past(mem_i[6:0]), $past(flags_o[0])} && !mem_we_o)
      else $error("rotate left to acc wrong");
   chk_rr_flags: assert property (@(posedge clock_i) disable iff (rst_i)
      go && op_i == 5'h03 |=> $stable(flags_o) &&
      mem_wdata_o == {$past(mem_i[0]), $past(mem_i[7:1])})
      else $error("rotate right wrong");
   chk_rra_acc: assert property (@(posedge clock_i) disable iff (rst_i)
      go && op_i == 5'h04 |=> !mem_we_o && $stable(flags_o) && acc_we_o)
      else $error("rotate right to acc wrong");
   chk_rrc_carry: assert property (@(posedge clock_i) disable iff (rst_i)
      go && (op_i == 5'h05 || op_i == 5'h06) |=> flags_o[0] == $past(mem_i[0]))
      else $error("rotate right carry wrong");
   chk_sub_zero: assert property (@(posedge clock_i) disable iff (rst_i)
      go && op_i == 5'h09 |=> flags_o[2] == (acc_o == 8'h00))
      else $error("zero flag wrong");
   chk_sub_value: assert property (@(posedge clock_i) disable iff (rst_i)
      go && op_i == 5'h0B |=> acc_o == 8'($past(acc_o) - $past(imm_i)))
      else $error("subtract immediate wrong");
   chk_skip_dummy: assert property (@(posedge clock_i) disable iff (rst_i)
      discard_o |=> !discard_o)
      else $error("dummy cycle longer than one");
   chk_dec_skip: assert property (@(posedge clock_i) disable iff (rst_i)
      go && op_i == 5'h0C && mem_i == 8'h01 |=> discard_o && mem_wdata_o == 8'h00)
      else $error("decrement skip wrong");
   chk_bit_skip: assert property (@(posedge clock_i) disable iff (rst_i)
      go && op_i == 5'h12 |=> discard_o == $past(mem_i[bit_sel_i]) && !mem_we_o)
      else $error("bit test skip wrong");
   chk_swap_mem: assert property (@(posedge clock_i) disable iff (rst_i)
      go && op_i == 5'h13 |=> mem_wdata_o == {$past(mem_i[3:0]), $past(mem_i[7:4])})
      else $error("swap wrong");
   cov_skip: cover property (@(posedge clock_i) go && op_i == 5'h0E ##1 discard_o);
   cov_sbc: cover property (@(posedge clock_i) go && op_i == 5'h08);
   cov_rlc: cover property (@(posedge clock_i) go && op_i == 5'h01);
   cov_bit_skip: cover property (@(posedge clock_i) go && op_i == 5'h12 ##1 discard_o);
   cov_deca_skip: cover property (@(posedge clock_i) go && op_i == 5'h0D ##1 discard_o);
   ////////////////////////////////////////////////////////////////////////
   // Further checks, one or more for each instruction class and destination except rotate left through carry to memory.
   chk_rotate_left_thru_carry_to_acc_carry: assert property (@(posedge clock_i) disable iff (rst_i)
      go && op_i == 5'h02 |=>
      acc_we_o &&
      flags_o[0] == $past(mem_i[7]) &&
      flags_o[3:1] == $past(flags_o[3:1]))
      else $error("rotate left to acc carry wrong");
   chk_rr_dest: assert property (@(posedge clock_i) disable iff (rst_i)
      go && op_i == 5'h03 |=>
      mem_we_o &&
      !acc_we_o &&
      acc_o == $past(acc_o))
      else $error("rotate right destination wrong");
   chk_rra_value: assert property (@(posedge clock_i) disable iff (rst_i)
      go && op_i == 5'h04 |=>
      acc_o == {$past(mem_i[0]), $past(mem_i[7:1])} &&
      acc_we_o &&
      !mem_we_o)
      else $error("rotate right to acc value wrong");
   chk_rrc_mem: assert property (@(posedge clock_i) disable iff (rst_i)
      go && op_i == 5'h05 |=>
      mem_we_o &&
      mem_wdata_o == {$past(flags_o[0]), $past(mem_i[7:1])} &&
      flags_o[3:1] == $past(flags_o[3:1]))
      else $error("rotate right carry memory wrong");
   chk_rrc_keep: assert property (@(posedge clock_i) disable iff (rst_i)
      go && op_i == 5'h05 |=>
      !acc_we_o &&
      !discard_o &&
      $stable(acc_o))
      else $error("rotate right carry touched acc");
   chk_rotate_right_thru_carry_to_acc_acc: assert property (@(posedge clock_i) disable iff (rst_i)
      go && op_i == 5'h06 |=>
      acc_we_o &&
      !mem_we_o &&
      acc_o == {$past(flags_o[0]), $past(mem_i[7:1])})
      else $error("rotate right carry to acc wrong");
   chk_sbc_acc: assert property (@(posedge clock_i) disable iff (rst_i)
      go && op_i == 5'h07 |=>
      acc_we_o &&
      !mem_we_o &&
      acc_o == 8'($past(acc_o) + ~$past(mem_i) + {7'h00, $past(flags_o[0])}))
      else $error("subtract with borrow to acc wrong");
   chk_subtract_with_borrow_to_mem_mem: assert property (@(posedge clock_i) disable iff (rst_i)
      go && op_i == 5'h08 |=>
      mem_we_o &&
      !acc_we_o &&
      mem_wdata_o == 8'($past(acc_o) + ~$past(mem_i) + {7'h00, $past(flags_o[0])}))
      else $error("subtract with borrow to memory wrong");
   chk_subtract_with_borrow_to_mem_zero: assert property (@(posedge clock_i) disable iff (rst_i)
      go && op_i == 5'h08 |=>
      flags_o[2] == (mem_wdata_o == 8'h00) &&
      acc_o == $past(acc_o) &&
      !discard_o)
      else $error("subtract with borrow zero flag wrong");
   chk_sub_carry: assert property (@(posedge clock_i) disable iff (rst_i)
      go && op_i == 5'h09 |=>
      flags_o[0] == ($past(acc_o) >= $past(mem_i)) &&
      acc_we_o &&
      !mem_we_o)
      else $error("subtract carry wrong");
   chk_sub_half: assert property (@(posedge clock_i) disable iff (rst_i)
      go && op_i == 5'h09 |=>
      flags_o[1] == ($past(acc_o[3:0]) >= $past(mem_i[3:0])) &&
      acc_o == 8'($past(acc_o) - $past(mem_i)) &&
      !discard_o)
      else $error("subtract half carry wrong");
   chk_sub_ovf: assert property (@(posedge clock_i) disable iff (rst_i)
      go && op_i == 5'h09 |=>
      flags_o[3] == (($past(acc_o[7]) != $past(mem_i[7])) &&
      (acc_o[7] != $past(acc_o[7]))) &&
      acc_we_o)
      else $error("subtract overflow wrong");
   chk_subtract_to_mem_mem: assert property (@(posedge clock_i) disable iff (rst_i)
      go && op_i == 5'h0A |=>
      mem_we_o &&
      mem_wdata_o == 8'($past(acc_o) - $past(mem_i)) &&
      acc_o == $past(acc_o))
      else $error("subtract to memory wrong");
   chk_subi_zero: assert property (@(posedge clock_i) disable iff (rst_i)
      go && op_i == 5'h0B |=>
      flags_o[2] == (acc_o == 8'h00) &&
      acc_we_o &&
      !mem_we_o)
      else $error("subtract immediate zero flag wrong");
   chk_dec_noskip: assert property (@(posedge clock_i) disable iff (rst_i)
      go && op_i == 5'h0C && mem_i != 8'h01 |=>
      !discard_o &&
      mem_we_o &&
      mem_wdata_o == 8'($past(mem_i) - 8'h01) &&
      $stable(flags_o))
      else $error("decrement without skip wrong");
   chk_deca_acc: assert property (@(posedge clock_i) disable iff (rst_i)
      go && op_i == 5'h0D |=>
      acc_o == 8'($past(mem_i) - 8'h01) &&
      !mem_we_o &&
      discard_o == (acc_o == 8'h00) &&
      $stable(flags_o))
      else $error("decrement to acc wrong");
   chk_inc_mem: assert property (@(posedge clock_i) disable iff (rst_i)
      go && op_i == 5'h0E |=>
      mem_we_o &&
      mem_wdata_o == 8'($past(mem_i) + 8'h01) &&
      discard_o == (mem_wdata_o == 8'h00) &&
      $stable(flags_o))
      else $error("increment skip wrong");
   chk_inca_acc: assert property (@(posedge clock_i) disable iff (rst_i)
      go && op_i == 5'h0F |=>
      acc_o == 8'($past(mem_i) + 8'h01) &&
      !mem_we_o &&
      discard_o == (acc_o == 8'h00) &&
      $stable(flags_o))
      else $error("increment to acc wrong");
   chk_set_byte: assert property (@(posedge clock_i) disable iff (rst_i)
      go && op_i == 5'h10 |=>
      mem_we_o &&
      mem_wdata_o == 8'hFF &&
      $stable(flags_o))
      else $error("byte set wrong");
   chk_set_bit: assert property (@(posedge clock_i) disable iff (rst_i)
      go && op_i == 5'h11 |=>
      mem_we_o &&
      mem_wdata_o == ($past(mem_i) | (8'h01 << $past(bit_sel_i))) &&
      $stable(flags_o))
      else $error("bit set wrong");
   chk_bit_keep: assert property (@(posedge clock_i) disable iff (rst_i)
      go && op_i == 5'h12 |=>
      $stable(flags_o) &&
      !acc_we_o &&
      $stable(acc_o))
      else $error("bit test changed state");
   chk_swap_keep: assert property (@(posedge clock_i) disable iff (rst_i)
      go && op_i == 5'h13 |=>
      mem_we_o &&
      !acc_we_o &&
      $stable(flags_o))
      else $error("swap changed flags");
   chk_dummy_quiet: assert property (@(posedge clock_i) disable iff (rst_i)
      discard_o |=>
      !mem_we_o &&
      !acc_we_o &&
      !discard_o)
      else $error("op executed in dummy cycle");
   chk_skip_source: assert property (@(posedge clock_i) disable iff (rst_i)
      discard_o |->
      busy_o &&
      $past(go) &&
      $past(state_r) == sskx_st_run)
      else $error("dummy cycle without skip");
   chk_idle_quiet: assert property (@(posedge clock_i) disable iff (rst_i)
      !go |=>
      !mem_we_o &&
      !acc_we_o &&
      !discard_o &&
      $stable(flags_o))
      else $error("output changed without op");
endmodule
`default_nettype wire

/* File: dv/sskx_dmem_model.sv */
// Data memory model that feeds and absorbs the execution datapath.
`timescale 1ns/100ps
`default_nettype none
module sskx_dmem_model (
   input wire logic clock_i,
   input wire logic take_i,
   input wire logic [3:0] addr_i,
   input wire logic we_i,
   input wire logic [7:0] wdata_i,
   output logic [7:0] rdata_o
);
   logic [7:0] mem [16];
   logic [3:0] waddr_r;
   initial begin
      for (int i = 0; i < 16; i++) begin
         mem[i] = 8'h3B * i[7:0] + 8'h11;
      end
      mem[0] = 8'h00;
      mem[1] = 8'h01;
      mem[2] = 8'hFF;
      mem[3] = 8'h80;
      mem[4] = 8'h7F;
      waddr_r = 4'h0;
   end
   assign rdata_o = mem[addr_i];
   // The write lands one cycle after the take, at the address seen then.
   always @(posedge clock_i) begin
      if (take_i) begin
         waddr_r <= addr_i;
      end
      if (we_i) begin
         mem[waddr_r] <= wdata_i;
      end
   end
endmodule
`default_nettype wire

/* File: dv/shift_subtract_skip_execute_tb_top.sv */
// Self-checking testbench for the shift, subtract and skip datapath.
`timescale 1ns/100ps
`default_nettype none
module shift_subtract_skip_execute_tb_top;
   import sskx_pkg::*;
   typedef struct {logic mwe; logic [7:0] wd; logic awe; logic [7:0] acc; logic [3:0] fl;
      logic sk;} sskx_note_type;
   logic clock_i, rst_i, issue_i, acc_we_o, mem_we_o, discard_o, busy_o, take;
   logic [4:0] op_i;
   logic [7:0] mem_i, imm_i, flags_i, acc_o, mem_wdata_o;
   logic [2:0] bit_sel_i;
   logic [3:0] flags_o, addr_i;
   logic [31:0] rng;
   logic [7:0] exp_acc;
   logic [3:0] exp_fl;
   sskx_note_type notes[$];
   int miscompares, n_compared, k;
   assign take = issue_i & ~busy_o;
   sskx_exec uut (.clock_i(clock_i), .rst_i(rst_i), .issue_i(issue_i), .op_i(op_i),
      .mem_i(mem_i), .imm_i(imm_i), .bit_sel_i(bit_sel_i), .flags_i(flags_i), .acc_o(acc_o),
      .flags_o(flags_o), .mem_wdata_o(mem_wdata_o), .mem_we_o(mem_we_o), .acc_we_o(acc_we_o),
      .discard_o(discard_o), .busy_o(busy_o));
   sskx_dmem_model pm (.clock_i(clock_i), .take_i(take), .addr_i(addr_i), .we_i(mem_we_o),
      .wdata_i(mem_wdata_o), .rdata_o(mem_i));
   initial begin
      clock_i = 1'b0;
      forever #12.5 clock_i = ~clock_i;
   end
   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      s = s ^ (s << 5);
      return s;
   endfunction
   task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic stop_test();
      $display("compared %0d, mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // Drives one op, works out its effect and notes it for the monitor unless it is a bit test that does not skip.
   task automatic issue(input logic [4:0] op, input logic [2:0] b, input logic [7:0] x);
      sskx_note_type e;
      logic [7:0] m, r, s;
      logic [8:0] sum;
      logic [4:0] h;
      logic cin;
      @(posedge clock_i);
      rng = xs(rng);
      issue_i <= 1'b1;
      op_i <= op;
      bit_sel_i <= b;
      imm_i <= x;
      flags_i <= rng[31:24];
      addr_i <= k[3:0];
      m = pm.mem[k[3:0]];
      k++;
      r = m;
      e.sk = 1'b0;
      case (op)
         5'h01, 5'h02: begin
            r = {m[6:0], exp_fl[0]};
            exp_fl[0] = m[7];
         end
         5'h03, 5'h04: r = {m[0], m[7:1]};
         5'h05, 5'h06: begin
            r = {exp_fl[0], m[7:1]};
            exp_fl[0] = m[0];
         end
         5'h07, 5'h08, 5'h09, 5'h0A, 5'h0B: begin
            s = (op == 5'h0B) ? x : m;
            cin = (op == 5'h07 || op == 5'h08) ? exp_fl[0] : 1'b1;
            sum = {1'b0, exp_acc} + {1'b0, ~s} + {8'h00, cin};
            h = {1'b0, exp_acc[3:0]} + {1'b0, ~s[3:0]} + {4'h0, cin};
            r = sum[7:0];
            exp_fl = {(exp_acc[7] == ~s[7]) && (r[7] != exp_acc[7]), r == 8'h00, h[4], sum[8]};
         end
         5'h0C, 5'h0D: r = m - 8'h01;
         5'h0E, 5'h0F: r = m + 8'h01;
         5'h10: r = 8'hFF;
         5'h11: r = m | (8'h01 << b);
         5'h12: e.sk = m[b];
         default: r = {m[3:0], m[7:4]};
      endcase
      if (op inside {5'h0C, 5'h0D, 5'h0E, 5'h0F}) begin
         e.sk = (r == 8'h00);
      end
      e.awe = op inside {5'h02, 5'h04, 5'h06, 5'h07, 5'h09, 5'h0B, 5'h0D, 5'h0F};
      e.mwe = !e.awe && op != 5'h12;
      exp_acc = e.awe ? r : exp_acc;
      e.wd = r;
      e.acc = exp_acc;
      e.fl = exp_fl;
      if (op != 5'h12 || e.sk) begin
         notes.push_back(e);
      end
      if (e.sk) begin
         // An op offered during the dummy cycle must be ignored.
         @(posedge clock_i);
         op_i <= 5'h10;
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   always @(negedge clock_i) begin
      sskx_note_type e;
      if (rst_i === 1'b0 && (mem_we_o | acc_we_o | discard_o) !== 1'b0) begin
         if (notes.size() == 0) begin
            cmp({mem_we_o, acc_we_o, discard_o}, 8'h00);
         end else begin
            e = notes.pop_front();
            cmp({7'h00, mem_we_o}, {7'h00, e.mwe});
            cmp({7'h00, acc_we_o}, {7'h00, e.awe});
            cmp({7'h00, discard_o}, {7'h00, e.sk});
            cmp({7'h00, busy_o}, {7'h00, e.sk});
            cmp(acc_o, e.acc);
            cmp({4'h0, flags_o}, {4'h0, e.fl});
            if (e.mwe) begin
               cmp(mem_wdata_o, e.wd);
            end
         end
      end
   end
   initial begin
      rng = 32'hD33B22D6;
      exp_acc = 8'h00;
      exp_fl = 4'h0;
      k = 0;
      rst_i = 1'b1;
      issue_i = 1'b0;
      op_i = 5'h00;
      imm_i = 8'h00;
      bit_sel_i = 3'h0;
      flags_i = 8'h00;
      addr_i = 4'h0;
      repeat (6) @(posedge clock_i);
      rst_i <= 1'b0;
      @(negedge clock_i);
      cmp(acc_o, 8'h00);
      cmp({4'h0, flags_o}, 8'h00);
      issue(5'h0C, 3'h0, 8'h00);
      issue(5'h0C, 3'h0, 8'h00);
      issue(5'h0E, 3'h0, 8'h00);
      issue(5'h09, 3'h0, 8'h00);
      issue(5'h08, 3'h0, 8'h00);
      issue(5'h01, 3'h0, 8'h00);
      issue(5'h02, 3'h0, 8'h00);
      issue(5'h03, 3'h0, 8'h00);
      issue(5'h04, 3'h0, 8'h00);
      issue(5'h05, 3'h0, 8'h00);
      issue(5'h06, 3'h0, 8'h00);
      issue(5'h0D, 3'h0, 8'h00);
      issue(5'h0F, 3'h0, 8'h00);
      issue(5'h10, 3'h0, 8'h00);
      issue(5'h11, 3'h5, 8'h00);
      issue(5'h12, 3'h7, 8'h00);
      issue(5'h13, 3'h0, 8'h00);
      issue(5'h0B, 3'h0, 8'h5A);
      for (int i = 0; i < 400; i++) begin
         rng = xs(rng);
         issue(5'h01 + 5'(rng % 19), rng[10:8], rng[23:16]);
      end
      @(posedge clock_i);
      issue_i <= 1'b0;
      for (int i = 0; i < 20 && notes.size() != 0; i++) begin
         @(posedge clock_i);
      end
      if (notes.size() != 0) begin
         miscompares++;
      end
      stop_test();
   end
endmodule
`default_nettype wire
